// >>> src/mode_six_dram.sv
// DRAM end: mode register six, parity latency / persistence from
// mode register five, and the sticky parity and CRC status flags.
// Assumes the controller drives the link synchronous to SYS_CLK.
`timescale 1ns/100ps
module mode_six_dram
  import mode_six_pkg::*;
(
  input  wire logic        SYS_CLK,        // Command clock
  input  wire logic        NRST,           // Sync reset, active low
  input  wire logic        CLK_EN,         // Low freezes all state
  input  wire logic        CRC_ERR_IN,     // Write CRC fail pulse
  ca_link_if.dram          LINK,           // Command/address pins
  output logic             PAR_ERR,        // Parity status flag
  output logic             CRC_ERR,        // CRC status flag
  output logic [2:0]       PAR_LATENCY,    // Parity latency code
  output logic             PAR_PERSIST,    // Persistent checking on
  output logic [2:0]       DATA_RATE,      // Rate field 12:10
  output logic             VREF_CAL_EN,    // Calibration enable
  output logic             VREF_RANGE,     // Calibration range
  output logic [5:0]       VREF_VALUE,     // Calibration step
  output logic [4:0]       MR6_RESERVED,   // Bits 21,17,13,9,8
  output logic             VREF_MON_EN,    // Reference on DQ[3:0]
  output logic             CMD_EXEC,       // Command executed pulse
  output logic             CMD_DROP        // Command refused pulse
);

  // All state of the DRAM end
  typedef struct packed {
    logic [2:0] pl;        // Parity latency code
    logic       persist;   // Persistent parity mode
    logic       par_err;   // Sticky parity status
    logic       crc_err;   // Sticky CRC status
    logic [2:0] rate;      // Data rate field
    logic [4:0] rsv;       // Reserved bits as written
    logic       vref_en;   // Calibration enable
    logic       vref_rng;  // Calibration range
    logic [5:0] vref_val;  // Calibration step
    logic       mon;       // Reference monitor on
    logic       exec;      // Executed pulse
    logic       drop;      // Refused pulse
  } dram_state_t;

  dram_state_t state_ff;   // Registered state
  dram_state_t nxt_state;  // Next state

  logic [21:0] word;       // Mode word from the pins
  logic        is_cmd;     // Chip selected this cycle
  logic        is_mrs;     // Mode register set decode
  logic        pl_legal;   // Latency code is a checking code
  logic        check_on;   // Parity checking active
  logic        par_bad;    // Parity mismatch seen

  // Pin decode and parity check
  always_comb
  begin
    word     = mode_word(LINK.bg, LINK.ba, LINK.a17, LINK.addr);
    is_cmd   = !LINK.cs_n;
    is_mrs   = LINK.act_n && !LINK.ras_n && !LINK.cas_n && !LINK.we_n;
    // Only four, five, six clocks check
    pl_legal = (state_ff.pl == PL_FOUR) || (state_ff.pl == PL_FIVE) ||
               (state_ff.pl == PL_SIX);
    check_on = pl_legal && (state_ff.persist || !state_ff.par_err);
    par_bad  = check_on && (ca_parity(LINK.act_n, LINK.ras_n, LINK.cas_n,
                            LINK.we_n, LINK.bg, LINK.ba, LINK.a17,
                            LINK.addr) != LINK.par);
  end

  // Next-state logic
  always_comb
  begin
    nxt_state      = state_ff;
    // Frozen while clock enable is low, pulses included
    if (CLK_EN)
    begin
      nxt_state.exec = 1'b0;
      nxt_state.drop = 1'b0;
      if (is_cmd)
      begin
        // Failing command: flag and drop
        if (par_bad)
        begin
          nxt_state.par_err = 1'b1;
          nxt_state.drop    = 1'b1;
        end
        // Passing command executes
        else
        begin
          nxt_state.exec = 1'b1;
          if (is_mrs)
          begin
            unique case (word[SEL_HI:SEL_LO])
              // Register six write
              SEL_MR6:
              begin
                nxt_state.rate    = word[RATE_HI:RATE_LO];
                nxt_state.rsv     = {word[BIT_RSV21], word[BIT_RSV17],
                                     word[BIT_RSV13], word[BIT_RSV9],
                                     word[BIT_RSV8]};
                nxt_state.vref_en = word[BIT_VREF_EN];
                if (word[BIT_VREF_EN])
                begin
                  nxt_state.vref_rng = word[BIT_VREF_RNG];
                  if (word[VAL_HI:VAL_LO] <= VREF_TOP)
                  begin
                    nxt_state.vref_val = word[VAL_HI:VAL_LO];
                  end
                end
              end
              // Register five write
              SEL_MR5:
              begin
                nxt_state.pl      = word[PL_HI:PL_LO];
                nxt_state.persist = word[BIT_PERSIST];
                if (!word[BIT_PAR_STAT])
                begin
                  nxt_state.par_err = 1'b0;
                end
                if (!word[BIT_CRC_STAT])
                begin
                  nxt_state.crc_err = 1'b0;
                end
              end
              // Other registers are outside this block
              default:
              begin
                nxt_state.exec = 1'b1;
              end
            endcase
          end
        end
      end
      if (CRC_ERR_IN)
      begin
        nxt_state.crc_err = 1'b1;
      end
      nxt_state.mon = nxt_state.vref_en;
    end
  end

  // State register
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      state_ff          <= '0;
      state_ff.pl       <= PL_RESET;
      state_ff.rate     <= RATE_RESET;
      state_ff.vref_val <= VAL_RESET;
    end
    // Normal update
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_comb
  begin
    PAR_ERR      = state_ff.par_err;
    CRC_ERR      = state_ff.crc_err;
    PAR_LATENCY  = state_ff.pl;
    PAR_PERSIST  = state_ff.persist;
    DATA_RATE    = state_ff.rate;
    VREF_CAL_EN  = state_ff.vref_en;
    VREF_RANGE   = state_ff.vref_rng;
    VREF_VALUE   = state_ff.vref_val;
    MR6_RESERVED = state_ff.rsv;
    VREF_MON_EN  = state_ff.mon;
    CMD_EXEC     = state_ff.exec;
    CMD_DROP     = state_ff.drop;
  end

  // Notes on the pins:
  // The monitor enable only tells the pad ring to route the
  // reference to a low data pin; no analog logic lives here.
  // Parity latency is treated as a checking switch; the
  // execution delay it implies belongs to the command pipeline.
  // Status writes through register five clear a flag only when
  // the written bit is zero, so writing one never clears it.
  // A parity error on the same cycle as a clearing write wins,
  // because the failing write itself is never executed.
  // Calibration value codes above the top step are ignored and
  // the previous step is kept, so the reference never lands on
  // an undefined level.
  // Writes with calibration disabled still store the enable and
  // rate, but keep range and value; this prevents a stray write
  // from moving the reference outside training.
  // Reserved bits are stored only so that a checker can see
  // what the controller programmed; nothing here acts on them.
  // The select code seven is never decoded as a register and
  // behaves as any other foreign register write.
  // Commands other than mode register set that pass parity are reported
  // on the executed pulse only; their decode is outside this block.

endmodule : mode_six_dram

// >>> inc/mode_six_pkg.sv
// Shared constants, mode word layout and parity helper for the DRAM
// mode register six / CA parity status pair.
// Assumes both ends sample the command bus on the same clock edge.
package mode_six_pkg;

  // Mode register select codes, carried on mode word bits 20:18
  localparam logic [2:0] SEL_MR5      = 3'h5;
  localparam logic [2:0] SEL_MR6      = 3'h6;
  localparam logic [2:0] SEL_UNUSED   = 3'h7;

  // Mode word field positions
  localparam int BIT_RSV21      = 21;
  localparam int SEL_HI         = 20;
  localparam int SEL_LO         = 18;
  localparam int BIT_RSV17      = 17;
  localparam int BIT_RSV13      = 13;
  localparam int RATE_HI        = 12;
  localparam int RATE_LO        = 10;
  localparam int BIT_RSV9       = 9;
  localparam int BIT_RSV8       = 8;
  localparam int BIT_VREF_EN    = 7;
  localparam int BIT_VREF_RNG   = 6;
  localparam int VAL_HI         = 5;
  localparam int VAL_LO         = 0;
  localparam int BIT_PERSIST    = 9;
  localparam int BIT_PAR_STAT   = 4;
  localparam int BIT_CRC_STAT   = 3;
  localparam int PL_HI          = 2;
  localparam int PL_LO          = 0;

  // Parity latency codes
  localparam logic [2:0] PL_OFF       = 3'h0;
  localparam logic [2:0] PL_FOUR      = 3'h1;
  localparam logic [2:0] PL_FIVE      = 3'h2;
  localparam logic [2:0] PL_SIX       = 3'h3;

  // Data rate codes and the boundary between them
  localparam logic [2:0] RATE_LE_1333 = 3'h0;
  localparam logic [2:0] RATE_LE_1866 = 3'h1;
  localparam int         RATE_EDGE    = 1333;

  // Highest legal calibration step (fifty steps, 0..49)
  localparam logic [5:0] VREF_TOP     = 6'h31;

  // Reset values
  localparam logic [2:0] PL_RESET     = 3'h0;
  localparam logic [2:0] RATE_RESET   = 3'h0;
  localparam logic [5:0] VAL_RESET    = 6'h00;

  // Build the 22-bit mode word from the address pins (16:14 unmapped)
  function automatic logic [21:0] mode_word(
    input logic [1:0]  bg,
    input logic [1:0]  ba,
    input logic        a17,
    input logic [13:0] a
  );
    mode_word = {bg, ba, a17, 3'h0, a};
  endfunction : mode_word

  // Even parity over the covered command/address pins
  function automatic logic ca_parity(
    input logic        act_n,
    input logic        ras_n,
    input logic        cas_n,
    input logic        we_n,
    input logic [1:0]  bg,
    input logic [1:0]  ba,
    input logic        a17,
    input logic [13:0] a
  );
    ca_parity = ^{act_n, ras_n, cas_n, we_n, bg, ba, a17, a};
  endfunction : ca_parity

endpackage : mode_six_pkg

// >>> inc/ca_link_if.sv
// Command/address link between memory controller and DRAM end.
// Assumes one shared clock; the testbench owns the clock and wiring.
`timescale 1ns/100ps
interface ca_link_if;
  logic        cs_n;    // Chip select, low = command
  logic        act_n;   // Activate strobe
  logic        ras_n;   // Row strobe / A16
  logic        cas_n;   // Column strobe / A15
  logic        we_n;    // Write enable / A14
  logic [1:0]  bg;      // Bank group
  logic [1:0]  ba;      // Bank address
  logic        a17;     // Address 17
  logic [13:0] addr;    // Address 13..0
  logic        par;     // Command/address parity
  logic        cke;     // Clock enable pin, not in parity
  logic        odt;     // Termination control, not in parity

  // Controller drives everything
  modport ctrl (output cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a17,
                output addr, par, cke, odt);
  // DRAM receives everything
  modport dram (input cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a17,
                input addr, par, cke, odt);
endinterface : ca_link_if

// >>> src/mode_six_ctrl.sv
// Controller end: turns mode register write requests into MRS
// commands with correct parity, inverted when REQ_BAD_PAR is high; idles the bus as deselect.
// Assumes one request at a time from a local sequencer.
`timescale 1ns/100ps
module mode_six_ctrl
  import mode_six_pkg::*;
#(
  parameter int RATE_MBPS = 1600     // Operating data rate
)
(
  input  wire logic        SYS_CLK,     // Command clock
  input  wire logic        NRST,        // Sync reset, active low
  input  wire logic        CLK_EN,      // Low freezes all state
  input  wire logic        REQ_VALID,   // Write request
  input  wire logic [2:0]  REQ_SEL,     // Target register
  input  wire logic [17:0] REQ_OP,      // Mode bits 17:0
  input  wire logic        REQ_BAD_PAR, // Send inverted parity
  output logic             REQ_READY,   // Request can be taken
  ca_link_if.ctrl          LINK         // Command/address pins
);

  // Rate code fixed by the operating frequency
  localparam logic [2:0] RATE_CODE =
    (RATE_MBPS > RATE_EDGE) ? RATE_LE_1866 : RATE_LE_1333;

  typedef enum logic {IDLE, ISSUE} ctrl_phase_t;

  // All state of the controller end
  typedef struct packed {
    ctrl_phase_t phase;  // Idle or driving
    logic        cs_n;   // Chip select
    logic [1:0]  bg;     // Bank group
    logic [1:0]  ba;     // Bank address
    logic        a17;    // Address 17
    logic [13:0] addr;   // Address 13..0
    logic        par;    // Parity out
  } ctrl_state_t;

  ctrl_state_t state_ff;   // Registered state
  ctrl_state_t nxt_state;  // Next state
  logic [21:0] op;         // Sanitised mode word

  // Build word and next state
  always_comb
  begin
    op        = {1'b0, REQ_SEL, REQ_OP};
    nxt_state = state_ff;
    // Register six gets its mandatory fields
    if (REQ_SEL == SEL_MR6)
    begin
      op[BIT_RSV21]         = 1'b0;
      op[BIT_RSV17]         = 1'b0;
      op[BIT_RSV13]         = 1'b0;
      op[BIT_RSV9]          = 1'b0;
      op[BIT_RSV8]          = 1'b0;
      op[RATE_HI:RATE_LO]   = RATE_CODE;
      op[BIT_VREF_EN]       = 1'b1;
    end
    if (CLK_EN)
    begin
      unique case (state_ff.phase)
        // Take a request and drive MRS next cycle
        IDLE:
        begin
          if (REQ_VALID)
          begin
            nxt_state.phase = ISSUE;
            nxt_state.cs_n  = 1'b0;
            nxt_state.bg    = op[21:20];
            nxt_state.ba    = op[19:18];
            nxt_state.a17   = op[BIT_RSV17];
            nxt_state.addr  = op[13:0];
            nxt_state.par   = REQ_BAD_PAR ^ ca_parity(1'b1, 1'b0, 1'b0,
                              1'b0, op[21:20], op[19:18], op[BIT_RSV17],
                              op[13:0]);
          end
        end
        // Command held one cycle, then deselect
        ISSUE:
        begin
          nxt_state.phase = IDLE;
          nxt_state.cs_n  = 1'b1;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      state_ff       <= '0;
      state_ff.phase <= IDLE;
      state_ff.cs_n  <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Pins from the state register; command strobes, cke and odt are constants
  always_comb
  begin
    REQ_READY  = (state_ff.phase == IDLE);
    LINK.cs_n  = state_ff.cs_n;
    LINK.act_n = 1'b1;
    LINK.ras_n = 1'b0;
    LINK.cas_n = 1'b0;
    LINK.we_n  = 1'b0;
    LINK.bg    = state_ff.bg;
    LINK.ba    = state_ff.ba;
    LINK.a17   = state_ff.a17;
    LINK.addr  = state_ff.addr;
    LINK.par   = state_ff.par;
    LINK.cke   = 1'b1;
    LINK.odt   = 1'b0;
  end

endmodule : mode_six_ctrl

// >>> tb/mode_six_props.sv
// Concurrent checks on the command/address link and the DRAM end.
// Assumes one clock domain and the link signals handed in by name.
`timescale 1ns/100ps
module mode_six_props
  import mode_six_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        CLK_EN,
  input wire logic        CRC_ERR_IN,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bg,
  input wire logic [1:0]  ba,
  input wire logic        a17,
  input wire logic [13:0] addr,
  input wire logic        par,
  input wire logic        PAR_ERR,
  input wire logic        CRC_ERR,
  input wire logic [2:0]  PAR_LATENCY,
  input wire logic        PAR_PERSIST,
  input wire logic [2:0]  DATA_RATE,
  input wire logic        VREF_CAL_EN,
  input wire logic        VREF_RANGE,
  input wire logic [5:0]  VREF_VALUE,
  input wire logic        CMD_EXEC,
  input wire logic        CMD_DROP
);
  logic [2:0] sel;     // Register select off the pins
  logic       par_ok;  // Received parity matches
  logic       chk_on;  // Checking active this cycle
  logic       exec;    // Command will be carried out
  // Decode of the command on the wire
  assign sel    = {bg[0], ba};
  assign par_ok = (par == ^{act_n, ras_n, cas_n, we_n, bg, ba, a17, addr});
  assign chk_on = (PAR_LATENCY inside {PL_FOUR, PL_FIVE, PL_SIX}) &&
                  (PAR_PERSIST || !PAR_ERR);
  assign exec   = !cs_n && CLK_EN && (!chk_on || par_ok);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  // Command steps
  sequence s_cmd; !cs_n && CLK_EN; endsequence
  sequence s_mr6; exec && sel == SEL_MR6; endsequence

  property p_mrs_pins; !cs_n |-> act_n && !ras_n && !cas_n && !we_n;
  endproperty
  property p_bit21; !cs_n |-> !bg[1]; endproperty
  property p_cs_one; !cs_n |=> cs_n; endproperty
  property p_par_set;
    s_cmd ##0 (chk_on && !par_ok) |=> PAR_ERR && CMD_DROP && !CMD_EXEC;
  endproperty
  property p_par_hold;
    PAR_ERR && !(exec && sel == SEL_MR5 && !addr[BIT_PAR_STAT]) |=> PAR_ERR;
  endproperty
  property p_par_clear;
    exec && sel == SEL_MR5 && !addr[BIT_PAR_STAT] |=> !PAR_ERR;
  endproperty
  property p_crc_set; CRC_ERR_IN && CLK_EN |=> CRC_ERR; endproperty
  property p_crc_hold;
    CRC_ERR && !(exec && sel == SEL_MR5 && !addr[BIT_CRC_STAT]) |=> CRC_ERR;
  endproperty
  property p_exec; exec |=> CMD_EXEC && !CMD_DROP; endproperty
  property p_mr6_keep;
    s_cmd ##0 (sel != SEL_MR6) |=> $stable(VREF_VALUE) &&
      $stable(VREF_RANGE) && $stable(DATA_RATE);
  endproperty
  property p_mr6_write;
    s_mr6 |=> VREF_CAL_EN && VREF_RANGE == $past(addr[BIT_VREF_RNG]) &&
      DATA_RATE == $past(addr[RATE_HI:RATE_LO]);
  endproperty
  property p_value;
    s_mr6 ##0 (addr[VAL_HI:VAL_LO] <= VREF_TOP) |=>
      VREF_VALUE == $past(addr[VAL_HI:VAL_LO]);
  endproperty

  a_mrs_pins: assert property (p_mrs_pins)
    else $error("MRS pins not low");
  a_bit21: assert property (p_bit21)
    else $error("Reserved bit 21 driven high");
  a_cs_one: assert property (p_cs_one)
    else $error("Select held low too long");
  a_par_set: assert property (p_par_set)
    else $error("Parity failure not flagged or not dropped");
  a_par_hold: assert property (p_par_hold)
    else $error("Parity flag fell without clear");
  a_par_clear: assert property (p_par_clear)
    else $error("Parity flag not cleared");
  a_crc_set: assert property (p_crc_set)
    else $error("CRC flag not set");
  a_crc_hold: assert property (p_crc_hold)
    else $error("CRC flag fell without clear");
  a_exec: assert property (p_exec)
    else $error("Valid command not executed");
  a_mr6_keep: assert property (p_mr6_keep)
    else $error("Register six changed by other select");
  a_mr6_write: assert property (p_mr6_write)
    else $error("Register six fields not written");
  a_value: assert property (p_value)
    else $error("Calibration step not written");
endmodule : mode_six_props

// >>> tb/tb_dram_mode_six_and_ca_parity_status.sv
// Bench joining controller end and DRAM end over the link interface.
// Assumes a 100 MHz clock; a queue of notes pairs with result pulses.
`timescale 1ns/100ps
module tb_dram_mode_six_and_ca_parity_status;
  import mode_six_pkg::*;
  localparam int RATE    = 1600;  // Operating data rate
  localparam int MAX_CYC = 3000;  // Hang ceiling in cycles
  // Expected outcome of one command
  typedef struct packed {
    logic drop, par, crc, en, rng, per;
    logic [2:0] pl;
    logic [2:0] rate;
    logic [5:0] val;
  } note_t;
  logic sys_clk, nrst, clk_en, crc_in, req_valid, req_bad, req_ready;
  logic [2:0]  req_sel, pl, rate_o;
  logic [17:0] req_op;
  logic        par_err, crc_err, persist, cal_en, rng, mon, exec, drop;
  logic [5:0]  val;
  logic [4:0]  rsv;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  logic [31:0] seed       = 32'h0000_e178;
  note_t       q[$];      // Pending expectations
  note_t       m;         // Model state
  note_t       e;         // Note under comparison
  logic [2:0]  m_pl;      // Model latency code
  logic        m_per;     // Model persistent mode

  ca_link_if link();
  mode_six_ctrl #(.RATE_MBPS(RATE)) u_mode_six_ctrl (.SYS_CLK(sys_clk),
    .NRST(nrst), .CLK_EN(clk_en), .REQ_VALID(req_valid), .REQ_SEL(req_sel),
    .REQ_OP(req_op), .REQ_BAD_PAR(req_bad), .REQ_READY(req_ready),
    .LINK(link.ctrl));
  mode_six_dram u_mode_six_dram (.SYS_CLK(sys_clk), .NRST(nrst),
    .CLK_EN(clk_en), .CRC_ERR_IN(crc_in), .LINK(link.dram),
    .PAR_ERR(par_err), .CRC_ERR(crc_err), .PAR_LATENCY(pl),
    .PAR_PERSIST(persist), .DATA_RATE(rate_o), .VREF_CAL_EN(cal_en),
    .VREF_RANGE(rng), .VREF_VALUE(val), .MR6_RESERVED(rsv),
    .VREF_MON_EN(mon), .CMD_EXEC(exec), .CMD_DROP(drop));
  mode_six_props u_mode_six_props (.SYS_CLK(sys_clk), .NRST(nrst),
    .CLK_EN(clk_en), .CRC_ERR_IN(crc_in), .cs_n(link.cs_n),
    .act_n(link.act_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .bg(link.bg), .ba(link.ba), .a17(link.a17),
    .addr(link.addr), .par(link.par), .PAR_ERR(par_err),
    .CRC_ERR(crc_err), .PAR_LATENCY(pl), .PAR_PERSIST(persist),
    .DATA_RATE(rate_o), .VREF_CAL_EN(cal_en), .VREF_RANGE(rng),
    .VREF_VALUE(val), .CMD_EXEC(exec), .CMD_DROP(drop));

  // Free running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  // Single compare kind
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Predict outcome, then send one mode write through the controller
  task automatic mrs(input logic [2:0] sel, input logic [17:0] op,
                     input logic bad);
    logic on;
    int   n;
    on = (m_pl inside {PL_FOUR, PL_FIVE, PL_SIX}) && (m_per || !m.par);
    m.drop = on && bad;
    // Failing commands leave all state but the flag
    if (m.drop)
      m.par = 1'b1;
    else if (sel == SEL_MR6)
    begin
      m.en   = 1'b1;
      m.rng  = op[BIT_VREF_RNG];
      m.rate = (RATE > RATE_EDGE) ? RATE_LE_1866 : RATE_LE_1333;
      if (op[VAL_HI:VAL_LO] <= VREF_TOP)
        m.val = op[VAL_HI:VAL_LO];
    end
    else if (sel == SEL_MR5)
    begin
      m_pl  = op[PL_HI:PL_LO];
      m_per = op[BIT_PERSIST];
      if (!op[BIT_PAR_STAT])
        m.par = 1'b0;
      if (!op[BIT_CRC_STAT])
        m.crc = 1'b0;
    end
    m.pl  = m_pl;
    m.per = m_per;
    q.push_back(m);
    n = 0;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    req_sel   = sel;
    req_op    = op;
    req_bad   = bad;
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : mrs

  // Random operand with a legal or chosen step
  function automatic logic [17:0] rop(input logic [5:0] step);
    seed = xs(seed);
    return {seed[17:6], step};
  endfunction : rop

  // Result watcher: each pulse takes the oldest note
  initial
  begin
    forever
    begin
      @(posedge sys_clk);
      #1;
      if (exec === 1'b1 || drop === 1'b1)
      begin
        if (q.size() == 0)
          chk(6'h01, 6'h00);
        else
        begin
          e = q.pop_front();
          chk(6'(drop), 6'(e.drop));
          chk(6'(par_err), 6'(e.par));
          chk(6'(crc_err), 6'(e.crc));
          chk(6'(rate_o), 6'(e.rate));
          chk(6'({cal_en, rng}), 6'({e.en, e.rng}));
          chk(val, e.val);
          chk(6'(rsv), 6'h00);
          chk(6'(pl), 6'(e.pl));
          chk(6'(persist), 6'(e.per));
          chk(6'(mon), 6'(e.en));
        end
      end
    end
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == MAX_CYC)
    begin
      mismatches++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    nrst = 1'b0; clk_en = 1'b1; crc_in = 1'b0; req_valid = 1'b0;
    req_sel = 3'h0; req_op = 18'h0_0000; req_bad = 1'b0;
    m = '0; m_pl = PL_RESET; m_per = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 nrst = 1'b1;
    chk(6'({par_err, crc_err, persist, cal_en, mon, exec}), 6'h00);
    chk(6'(pl), 6'(PL_RESET));
    chk({rate_o, 3'h0}, {RATE_RESET, 3'h0});
    // Register six writes, boundary steps last
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      mrs(SEL_MR6, rop((i == 4) ? VREF_TOP + 6'h01 :
          (i == 5) ? VREF_TOP : 6'(seed % 32'd50)), 1'b0);
    end
    // Other selects leave register six alone
    for (int s = 0; s < 5; s++)
      mrs(3'(s), rop(6'h3f), 1'b0);
    // Every latency code with a bad command, then clear
    for (int p = 0; p < 8; p++)
    begin
      mrs(SEL_MR5, 18'(p), 1'b0);
      mrs(SEL_MR6, rop(6'h05), 1'b1);
      mrs(SEL_MR5, 18'(p), 1'b0);
    end
    // Flag stops checking unless persistent mode is on
    mrs(SEL_MR5, 18'h0_0001, 1'b0);
    mrs(SEL_MR6, rop(6'h10), 1'b1);
    mrs(SEL_MR6, rop(6'h11), 1'b1);
    mrs(SEL_MR5, 18'h0_0211, 1'b0);
    mrs(SEL_MR6, rop(6'h12), 1'b1);
    mrs(SEL_MR5, 18'h0_0001, 1'b0);
    // CRC flag sticks until a clearing write
    @(posedge sys_clk);
    #1 crc_in = 1'b1;
    m.crc = 1'b1;
    @(posedge sys_clk);
    #1 crc_in = 1'b0;
    mrs(3'h0, rop(6'h00), 1'b0);
    mrs(SEL_MR5, 18'h0_0008, 1'b0);
    mrs(SEL_MR5, 18'h0_0000, 1'b0);
    // Clock enable low freezes the CRC flag
    @(posedge sys_clk);
    #1 clk_en = 1'b0;
    crc_in = 1'b1;
    @(posedge sys_clk);
    #1 crc_in = 1'b0;
    chk(6'(crc_err), 6'h00);
    clk_en = 1'b1;
    chk(6'(mon), 6'(m.en));
    chk(6'(q.size()), 6'h00);
    finish_test();
  end
endmodule : tb_dram_mode_six_and_ca_parity_status
